// file: dbf_host.sv
`timescale 1ns/1ps
// Host on one data port: drives the word, both strobes and program enable
module dbf_host
  import dbf_pkg::*;
(
  input  wire logic             pclk,     // Bench clock
  input  wire logic [DBF_W-1:0] dut_out,  // Device drive value
  input  wire logic             dut_oe_n, // Low while device drives
  output logic      [DBF_W-1:0] pin,      // Resolved pin level
  output logic                  ld_stb,   // Load strobe
  output logic                  un_stb,   // Unload strobe
  output logic                  prog_n    // Offset program enable
);
  logic [DBF_W-1:0] drv_q = '0;  // Host drive value
  initial begin
    ld_stb = 1'b0;
    un_stb = 1'b0;
    prog_n = 1'b1;
  end
  // Device wins the wire while it drives, host otherwise
  assign pin = dut_oe_n ? drv_q : dut_out;
  // Word set up early and held well past the sync delay, then inverted
  // so a stale level can never pass for a stored one
  task automatic load(input logic [DBF_W-1:0] w);
    @(posedge pclk) drv_q <= w;
    repeat (6) @(posedge pclk);
    ld_stb <= 1'b1;
    repeat (12) @(posedge pclk);
    ld_stb <= 1'b0;
    drv_q  <= ~w;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask : load
  // One unload pulse, 120 ns frame against 125 ns for a load
  task automatic unload;
    @(posedge pclk) un_stb <= 1'b1;
    repeat (12) @(posedge pclk);
    un_stb <= 1'b0;
    repeat (11) @(posedge pclk);
    @(negedge pclk);
  endtask : unload
  // Real-time level with no strobe
  task automatic put(input logic [DBF_W-1:0] w);
    @(posedge pclk) drv_q <= w;
  endtask : put
  // Only called between frames, with the load strobe low
  task automatic set_prog(input logic v);
    @(posedge pclk) prog_n <= v;
  endtask : set_prog
endmodule : dbf_host

// file: dbf_pkg.sv
package dbf_pkg;

  localparam int DBF_W      = 18;              // Port and word width
  localparam int DBF_DEPTH  = 512;             // Words per FIFO
  localparam int DBF_AW     = 9;               // Pointer width
  localparam int DBF_CW     = 10;              // Word count width
  localparam int DBF_OFS_W  = 8;               // Offset width
  localparam int DBF_PA_W   = 12;              // APB address width

  localparam logic [DBF_CW-1:0]    DBF_FULL_CNT = 10'h200;  // Maximum words
  localparam logic [DBF_CW-1:0]    DBF_HALF_CNT = 10'h100;  // Half-full threshold
  localparam logic [DBF_OFS_W-1:0] DBF_OFS_DEF  = 8'h80;    // Default X and Y

  // APB register byte addresses
  localparam logic [DBF_PA_W-1:0] DBF_CTRL_ADDR  = 12'h000;  // Flush pulses
  localparam logic [DBF_PA_W-1:0] DBF_STAT_ADDR  = 12'h004;  // Flags and states
  localparam logic [DBF_PA_W-1:0] DBF_COUNT_ADDR = 12'h008;  // Word counts
  localparam logic [DBF_PA_W-1:0] DBF_OFS_ADDR   = 12'h00c;  // Offsets

  // Field positions
  localparam int DBF_CTRL_FLUSH = 0;   // Flush bit, one per channel
  localparam int DBF_ST_STRIDE  = 8;   // Status byte per channel
  localparam int DBF_ST_NE      = 0;   // Not-empty flag
  localparam int DBF_ST_NF      = 1;   // Not-full flag
  localparam int DBF_ST_HF      = 2;   // Half flag
  localparam int DBF_ST_AF      = 3;   // Almost flag
  localparam int DBF_ST_PRG     = 4;   // Programming state, 3 bits
  localparam int DBF_CNT_STRIDE = 16;  // Count field per channel
  localparam int DBF_OFS_STRIDE = 16;  // X then Y per channel

  // Offset programming window
  typedef enum logic [2:0] {
    DBF_PRG_IDLE = 3'b001,  // Fresh after reset, nothing loaded
    DBF_PRG_ONE  = 3'b010,  // X and Y loaded once
    DBF_PRG_DONE = 3'b100   // Window closed
  } dbf_prog_e;

  // One FIFO channel
  typedef struct packed {
    logic [DBF_DEPTH-1:0][DBF_W-1:0] mem;     // Word storage
    logic [DBF_AW-1:0]               wr_ptr;  // Next write slot
    logic [DBF_AW-1:0]               rd_ptr;  // Head slot
    logic [DBF_CW-1:0]               count;   // Words held
    logic [DBF_OFS_W-1:0]            ofs_x;   // Almost-empty offset
    logic [DBF_OFS_W-1:0]            ofs_y;   // Almost-full offset
    dbf_prog_e                       prog;    // Programming state
    logic                            ld_prev; // Load strobe last cycle
    logic                            un_prev; // Unload strobe last cycle
  } dbf_chan_s;

  // Whole top-level state
  typedef struct packed {
    dbf_chan_s [1:0]  ch;          // 0 is A-to-B, 1 is B-to-A
    logic [DBF_W-1:0] port_a_out;  // Port A output word
    logic [DBF_W-1:0] port_b_out;  // Port B output word
    logic [31:0]      prdata;      // APB read data
  } dbf_state_s;

endpackage : dbf_pkg

// file: dbf_sync.sv
`timescale 1ns/1ps
module dbf_sync
  import dbf_pkg::*;
#(
  parameter int W = 1                  // Bits synchronised
) (
  input  wire logic         pclk,      // System clock
  input  wire logic         presetn,   // Async reset, active low
  input  wire logic [W-1:0] d_async,   // Pin levels
  output logic      [W-1:0] d_sync     // Two-flop synchronised levels
);

  // Metastable stage feeds only the second stage
  typedef struct packed {
    logic [W-1:0] meta;  // First stage
    logic [W-1:0] sync;  // Second stage
  } dbf_sync_s;

  dbf_sync_s s_q;  // Registered state
  dbf_sync_s s_d;  // Next state

  // Shift one stage per clock
  always_comb begin
    s_d.meta = d_async;
    s_d.sync = s_q.meta;
  end

  // Reset to zero; a zero reset pin holds its FIFO in reset until synced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign d_sync = s_q.sync;

endmodule : dbf_sync

// file: dbf_top.sv
`timescale 1ns/1ps
module dbf_top
  import dbf_pkg::*;
(
  input  wire logic                pclk,                    // System clock, 200 MHz
  input  wire logic                presetn,                 // Async reset, active low
  // APB slave
  input  wire logic                psel,                    // Slave select
  input  wire logic                penable,                 // Access phase
  input  wire logic                pwrite,                  // Write direction
  input  wire logic [DBF_PA_W-1:0] paddr,                   // Byte address
  input  wire logic [31:0]         pwdata,                  // Write data
  output logic      [31:0]         prdata,                  // Read data
  output logic                     pready,                  // Always ready
  output logic                     pslverr,                 // Unmapped address
  // Port A pins
  input  wire logic [DBF_W-1:0]    port_a_data_in,          // Port A level
  output logic      [DBF_W-1:0]    port_a_data_out,         // Port A drive value
  output logic                     port_a_data_oe_n,        // Low while driving A
  input  wire logic                port_a_drive_en,         // High enables A drivers
  input  wire logic                port_a_src_sel,          // High selects B-to-A head
  // Port B pins
  input  wire logic [DBF_W-1:0]    port_b_data_in,          // Port B level
  output logic      [DBF_W-1:0]    port_b_data_out,         // Port B drive value
  output logic                     port_b_data_oe_n,        // Low while driving B
  input  wire logic                port_b_drive_en,         // High enables B drivers
  input  wire logic                port_b_src_sel,          // High selects A-to-B head
  // A-to-B FIFO control and flags
  input  wire logic                fifo_ab_load_strobe,     // Store on rising edge
  input  wire logic                fifo_ab_unload_strobe,   // Advance on rising edge
  input  wire logic                fifo_ab_offset_prog_n,   // Low programs offsets
  input  wire logic                fifo_ab_reset_n,         // Low empties FIFO
  output logic                     fifo_ab_not_empty_n,     // Low when empty
  output logic                     fifo_ab_not_full_n,      // Low when full
  output logic                     fifo_ab_half_flag,       // High at half or more
  output logic                     fifo_ab_almost_flag,     // High near empty or full
  // B-to-A FIFO control and flags
  input  wire logic                fifo_ba_load_strobe,     // Store on rising edge
  input  wire logic                fifo_ba_unload_strobe,   // Advance on rising edge
  input  wire logic                fifo_ba_offset_prog_n,   // Low programs offsets
  input  wire logic                fifo_ba_reset_n,         // Low empties FIFO
  output logic                     fifo_ba_not_empty_n,     // Low when empty
  output logic                     fifo_ba_not_full_n,      // Low when full
  output logic                     fifo_ba_half_flag,       // High at half or more
  output logic                     fifo_ba_almost_flag      // High near empty or full
);

  localparam int SYW = 2 * (DBF_W + 4) + 4;  // Synchronised bit count

  dbf_state_s s_q;  // Registered state
  dbf_state_s s_d;  // Next state

  logic [SYW-1:0]   sy;         // Synchronised pins
  logic [DBF_W-1:0] din  [2];   // Input word per channel
  logic [1:0]       ld_s;       // Load strobe levels
  logic [1:0]       un_s;       // Unload strobe levels
  logic [1:0]       prg_n_s;    // Program enables
  logic [1:0]       rst_n_s;    // Channel resets
  logic             a_sel_s;    // Port A source select
  logic             b_sel_s;    // Port B source select
  logic             a_en_s;     // Port A drive enable
  logic             b_en_s;     // Port B drive enable
  logic [DBF_W-1:0] head [2];   // Head word per channel
  logic [1:0]       ld_edge;    // Load rising edge
  logic [1:0]       un_edge;    // Unload rising edge
  logic [1:0]       do_prog;    // Edge used for offsets
  logic [1:0]       do_wr;      // Word stored
  logic [1:0]       do_rd;      // Head advanced
  logic [1:0]       ne;         // Not-empty flags
  logic [1:0]       nf;         // Not-full flags
  logic [1:0]       hf;         // Half flags
  logic [1:0]       af;         // Almost flags
  logic [1:0]       flush;      // Software flush pulse
  logic             apb_wr;     // APB write accepted
  logic             apb_setup;  // APB setup phase
  logic             mapped;     // Address hits a register

  // Every port and FIFO pin is asynchronous to pclk; data rides with its strobe
  dbf_sync #(
    .W (SYW)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_async ({port_b_drive_en, port_a_drive_en, port_b_src_sel, port_a_src_sel,
               fifo_ba_reset_n, fifo_ba_offset_prog_n, fifo_ba_unload_strobe,
               fifo_ba_load_strobe, port_b_data_in,
               fifo_ab_reset_n, fifo_ab_offset_prog_n, fifo_ab_unload_strobe,
               fifo_ab_load_strobe, port_a_data_in}),
    .d_sync  (sy)
  );

  // Unpack synchronised pins
  assign din[0]     = sy[DBF_W-1:0];
  assign ld_s[0]    = sy[DBF_W];
  assign un_s[0]    = sy[DBF_W+1];
  assign prg_n_s[0] = sy[DBF_W+2];
  assign rst_n_s[0] = sy[DBF_W+3];
  assign din[1]     = sy[2*DBF_W+3:DBF_W+4];
  assign ld_s[1]    = sy[2*DBF_W+4];
  assign un_s[1]    = sy[2*DBF_W+5];
  assign prg_n_s[1] = sy[2*DBF_W+6];
  assign rst_n_s[1] = sy[2*DBF_W+7];
  assign a_sel_s    = sy[2*DBF_W+8];
  assign b_sel_s    = sy[2*DBF_W+9];
  assign a_en_s     = sy[2*DBF_W+10];
  assign b_en_s     = sy[2*DBF_W+11];

  // Head word shown while the FIFO holds data; falls through on first write
  assign head[0] = s_q.ch[0].mem[s_q.ch[0].rd_ptr];
  assign head[1] = s_q.ch[1].mem[s_q.ch[1].rd_ptr];

  // APB decode; zero wait states
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  always_comb begin
    if (paddr == DBF_CTRL_ADDR) begin
      mapped = 1'b1;
    end else if (paddr == DBF_STAT_ADDR) begin
      mapped = 1'b1;
    end else if (paddr == DBF_COUNT_ADDR) begin
      mapped = 1'b1;
    end else if (paddr == DBF_OFS_ADDR) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign flush   = (apb_wr && paddr == DBF_CTRL_ADDR) ? pwdata[DBF_CTRL_FLUSH +: 2] : 2'b00;

  // Next-state logic for both channels, ports and read data
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 2; i++) begin
      ld_edge[i] = ld_s[i] && !s_q.ch[i].ld_prev;
      un_edge[i] = un_s[i] && !s_q.ch[i].un_prev;
      s_d.ch[i].ld_prev = ld_s[i];
      s_d.ch[i].un_prev = un_s[i];
      // Flags follow the held word count
      ne[i] = (s_q.ch[i].count != '0);
      nf[i] = (s_q.ch[i].count != DBF_FULL_CNT);
      hf[i] = (s_q.ch[i].count >= DBF_HALF_CNT);
      af[i] = (s_q.ch[i].count <= {2'h0, s_q.ch[i].ofs_x}) ||
              (s_q.ch[i].count >= (DBF_FULL_CNT - {2'h0, s_q.ch[i].ofs_y}));
      // Offsets only before the first stored word; the host times the enable
      do_prog[i] = ld_edge[i] && !prg_n_s[i] && (s_q.ch[i].prog != DBF_PRG_DONE);
      do_wr[i]   = ld_edge[i] && !do_prog[i] && nf[i];
      do_rd[i]   = un_edge[i] && ne[i];
      if (!rst_n_s[i] || flush[i]) begin
        // Reset empties the channel; count zero yields the forced flags
        s_d.ch[i].wr_ptr = '0;
        s_d.ch[i].rd_ptr = '0;
        s_d.ch[i].count  = '0;
        s_d.ch[i].ofs_x  = DBF_OFS_DEF;
        s_d.ch[i].ofs_y  = DBF_OFS_DEF;
        s_d.ch[i].prog   = DBF_PRG_IDLE;
      end else begin
        if (do_prog[i]) begin
          case (s_q.ch[i].prog)
            DBF_PRG_IDLE: begin
              // First edge loads both offsets
              s_d.ch[i].ofs_x = din[i][DBF_OFS_W-1:0];
              s_d.ch[i].ofs_y = din[i][DBF_OFS_W-1:0];
              s_d.ch[i].prog  = DBF_PRG_ONE;
            end
            DBF_PRG_ONE: begin
              // Second edge rewrites Y only
              s_d.ch[i].ofs_y = din[i][DBF_OFS_W-1:0];
              s_d.ch[i].prog  = DBF_PRG_DONE;
            end
            default: begin
              s_d.ch[i].prog = DBF_PRG_DONE;
            end
          endcase
        end else if (ld_edge[i]) begin
          // Any data load edge closes the programming window
          s_d.ch[i].prog = DBF_PRG_DONE;
        end
        if (do_wr[i]) begin
          s_d.ch[i].mem[s_q.ch[i].wr_ptr] = din[i];
          s_d.ch[i].wr_ptr = s_q.ch[i].wr_ptr + 9'h1;
        end
        if (do_rd[i]) begin
          s_d.ch[i].rd_ptr = s_q.ch[i].rd_ptr + 9'h1;
        end
        s_d.ch[i].count = s_q.ch[i].count + {9'h0, do_wr[i]} - {9'h0, do_rd[i]};
      end
    end
    // Registered mux: the pin sees one clean change, never a decode glitch
    s_d.port_b_out = b_sel_s ? head[0] : din[0];
    s_d.port_a_out = a_sel_s ? head[1] : din[1];
    // Read data captured in setup phase, stable through access
    if (apb_setup) begin
      s_d.prdata = '0;
      if (paddr == DBF_STAT_ADDR) begin
        for (int i = 0; i < 2; i++) begin
          s_d.prdata[i*DBF_ST_STRIDE + DBF_ST_NE]       = ne[i];
          s_d.prdata[i*DBF_ST_STRIDE + DBF_ST_NF]       = nf[i];
          s_d.prdata[i*DBF_ST_STRIDE + DBF_ST_HF]       = hf[i];
          s_d.prdata[i*DBF_ST_STRIDE + DBF_ST_AF]       = af[i];
          s_d.prdata[i*DBF_ST_STRIDE + DBF_ST_PRG +: 3] = s_q.ch[i].prog;
        end
      end else if (paddr == DBF_COUNT_ADDR) begin
        for (int i = 0; i < 2; i++) begin
          s_d.prdata[i*DBF_CNT_STRIDE +: DBF_CW] = s_q.ch[i].count;
        end
      end else if (paddr == DBF_OFS_ADDR) begin
        for (int i = 0; i < 2; i++) begin
          s_d.prdata[i*DBF_OFS_STRIDE +: DBF_OFS_W]             = s_q.ch[i].ofs_x;
          s_d.prdata[i*DBF_OFS_STRIDE + DBF_OFS_W +: DBF_OFS_W] = s_q.ch[i].ofs_y;
        end
      end
    end
  end

  // State register; presetn clears all of it, memory contents included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata              = s_q.prdata;
  assign port_a_data_out     = s_q.port_a_out;
  assign port_b_data_out     = s_q.port_b_out;
  assign port_a_data_oe_n    = !a_en_s;
  assign port_b_data_oe_n    = !b_en_s;
  assign fifo_ab_not_empty_n = ne[0];
  assign fifo_ab_not_full_n  = nf[0];
  assign fifo_ab_half_flag   = hf[0];
  assign fifo_ab_almost_flag = af[0];
  assign fifo_ba_not_empty_n = ne[1];
  assign fifo_ba_not_full_n  = nf[1];
  assign fifo_ba_half_flag   = hf[1];
  assign fifo_ba_almost_flag = af[1];

  // Pins as seen before synchronisation, for reset and drive-enable checks
  logic [1:0] rst_pin;  // Raw channel resets
  logic [1:0] en_pin;   // Raw drive enables
  assign rst_pin = {fifo_ba_reset_n, fifo_ab_reset_n};
  assign en_pin  = {port_b_drive_en, port_a_drive_en};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Reset pin held long enough to pass the synchroniser and register
  sequence held_low(logic s);
    !s [*4];
  endsequence

  // First programming edge: do_prog while still DBF_PRG_IDLE
  sequence prog_first(int i);
    do_prog[i] && s_q.ch[i].prog == DBF_PRG_IDLE;
  endsequence

  // Per-channel checks
  for (genvar g = 0; g < 2; g++) begin : g_chk
    fill_step_a: assert property (
      do_wr[g] && !do_rd[g] && rst_n_s[g] && !flush[g]
      |=> s_q.ch[g].count == $past(s_q.ch[g].count) + 10'h1)
      else $error("store did not raise the word count");
    full_ignore_a: assert property (
      ld_edge[g] && !nf[g] && !un_edge[g] && rst_n_s[g] && !flush[g] |=> !nf[g])
      else $error("load while full changed the count");
    unload_step_a: assert property (
      un_edge[g] && ne[g] && !ld_edge[g] && rst_n_s[g] && !flush[g]
      |=> s_q.ch[g].rd_ptr == $past(s_q.ch[g].rd_ptr) + 9'h1
          && s_q.ch[g].count == $past(s_q.ch[g].count) - 10'h1)
      else $error("unload did not advance the head");
    empty_ignore_a: assert property (
      un_edge[g] && !ne[g] && !ld_edge[g] && rst_n_s[g] && !flush[g] |=> !ne[g] && $stable(s_q.ch[g].rd_ptr))
      else $error("unload while empty moved the head");
    reset_flags_a: assert property (
      held_low(rst_pin[g]) |-> !ne[g] && nf[g] && !hf[g] && af[g])
      else $error("reset did not force the flags");
    reset_ofs_a: assert property (
      held_low(rst_pin[g]) |-> s_q.ch[g].ofs_x == DBF_OFS_DEF && s_q.ch[g].ofs_y == DBF_OFS_DEF)
      else $error("reset did not restore default offsets");
    half_rise_a: assert property (
      $rose(hf[g]) |-> s_q.ch[g].count == DBF_HALF_CNT && $past(s_q.ch[g].count) == 10'h0ff)
      else $error("half flag rose at the wrong count");
    prog_both_a: assert property (
      prog_first(g) ##0 (rst_n_s[g] && !flush[g])
      |=> s_q.ch[g].ofs_x == $past(din[g][7:0]) && s_q.ch[g].ofs_y == $past(din[g][7:0])
          && $stable(s_q.ch[g].count))
      else $error("first programming edge mishandled");
    prog_y_a: assert property (
      do_prog[g] && s_q.ch[g].prog == DBF_PRG_ONE && rst_n_s[g] && !flush[g]
      |=> $stable(s_q.ch[g].ofs_x) && s_q.ch[g].ofs_y == $past(din[g][7:0])
          && $stable(s_q.ch[g].count))
      else $error("second programming edge mishandled");
    fall_thru_a: assert property (
      do_wr[g] && !ne[g] && !do_rd[g] && rst_n_s[g] && !flush[g] |=> head[g] == $past(din[g]))
      else $error("first word did not fall through");
    drive_en_a: assert property (
      en_pin[g] [*3] |-> (g == 0 ? !port_a_data_oe_n : !port_b_data_oe_n))
      else $error("drivers not enabled");
  end

  sel_b_a: assert property (
    b_sel_s |=> port_b_data_out == $past(head[0]))
    else $error("port B not showing stored data");
  sel_a_a: assert property (
    !a_sel_s |=> port_a_data_out == $past(din[1]))
    else $error("port A not showing real-time data");

endmodule : dbf_top

// file: testbench.sv
`timescale 1ns/1ps
// Self-checking bench: APB master, two port hosts, flag tracking
module testbench
  import dbf_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // Clock, reset, APB
  logic [DBF_PA_W-1:0] paddr = '0;  // APB address
  logic [31:0] pwdata = '0, prdata, ard;  // APB data, last read
  logic a_en = 1'b0, a_sel = 1'b0, b_en = 1'b0, b_sel = 1'b0, rst_ab = 1'b0, rst_ba = 1'b0;  // Port controls
  logic pready, pslverr, aerr, a_oe_n, b_oe_n, a_ld, a_un, a_pn, b_ld, b_un, b_pn;  // Handshakes
  logic [DBF_W-1:0] a_out, b_out, a_pin, b_pin;  // Port values
  logic [3:0] fab, fba;  // Not-empty, not-full, half, almost
  int miscompares = 0, samples_checked = 0, cyc = 0, n;  // Bookkeeping
  // AB is loaded from port A and unloaded by port B's host; BA the reverse
  dbf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_data_in(a_pin), .port_a_data_out(a_out), .port_a_data_oe_n(a_oe_n), .port_a_drive_en(a_en),
    .port_a_src_sel(a_sel), .port_b_data_in(b_pin), .port_b_data_out(b_out), .port_b_data_oe_n(b_oe_n),
    .port_b_drive_en(b_en), .port_b_src_sel(b_sel), .fifo_ab_load_strobe(a_ld), .fifo_ab_unload_strobe(b_un),
    .fifo_ab_offset_prog_n(a_pn), .fifo_ab_reset_n(rst_ab), .fifo_ab_not_empty_n(fab[3]),
    .fifo_ab_not_full_n(fab[2]), .fifo_ab_half_flag(fab[1]), .fifo_ab_almost_flag(fab[0]),
    .fifo_ba_load_strobe(b_ld), .fifo_ba_unload_strobe(a_un), .fifo_ba_offset_prog_n(b_pn),
    .fifo_ba_reset_n(rst_ba), .fifo_ba_not_empty_n(fba[3]), .fifo_ba_not_full_n(fba[2]),
    .fifo_ba_half_flag(fba[1]), .fifo_ba_almost_flag(fba[0]));
  dbf_host i_ha (.pclk(pclk), .dut_out(a_out), .dut_oe_n(a_oe_n), .pin(a_pin), .ld_stb(a_ld),
    .un_stb(a_un), .prog_n(a_pn));
  dbf_host i_hb (.pclk(pclk), .dut_out(b_out), .dut_oe_n(b_oe_n), .pin(b_pin), .ld_stb(b_ld),
    .un_stb(b_un), .prog_n(b_pn));
  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Expected flags from a word count and the two offsets
  function automatic logic [3:0] fx(input int c, input int x, input int y);
    return {c != 0, c != DBF_DEPTH, c >= 256, (c <= x) || (c >= DBF_DEPTH - y)};
  endfunction : fx
  // Distinct data word per index
  function automatic logic [DBF_W-1:0] wd(input int i);
    return 18'h2a5c3 ^ DBF_W'(i * 37);
  endfunction : wd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Settle past the sampling edge before looking
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : wt
  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [DBF_PA_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    ard  = prdata;
    aerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task final_report;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Hang guard, well above the ~25k cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rst_ab <= 1'b1;
    rst_ba <= 1'b1;
    wt(8);
    chk(32'({fab, fba}), 32'h55);
    apb(1'b0, DBF_OFS_ADDR, 32'h0);
    chk(ard, 32'h80808080);
    apb(1'b1, 12'h010, 32'hffffffff);
    chk(32'(aerr), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({ard[30:0], aerr}, 32'h1);
    // Two programming edges: X=Y=5, then Y alone to 3
    i_ha.set_prog(1'b0);
    i_ha.load(18'h00005);
    i_ha.load(18'h00003);
    i_ha.set_prog(1'b1);
    apb(1'b0, DBF_OFS_ADDR, 32'h0);
    chk(ard, 32'h80800305);
    apb(1'b0, DBF_COUNT_ADDR, 32'h0);
    chk({22'h0, ard[9:0]}, 32'h0);
    @(posedge pclk) b_sel <= 1'b1;
    b_en <= 1'b1;
    // Fill past full; the extra word must be dropped
    for (n = 0; n < 513; n++) begin
      i_ha.load(wd(n));
      chk(32'(fab), 32'(fx(n < 512 ? n + 1 : 512, 5, 3)));
      if (n == 0) chk(32'(b_out), 32'(wd(0)));
    end
    chk(32'(b_oe_n), 32'h0);
    // Drain past empty, words in order
    for (n = 0; n < 513; n++) begin
      if (n < 512) chk(32'(b_out), 32'(wd(n)));
      i_hb.unload();
      chk(32'(fab), 32'(fx(n < 511 ? 511 - n : 0, 5, 3)));
    end
    @(posedge pclk) b_sel <= 1'b0;
    i_ha.put(18'h2b4c1);
    wt(8);
    chk(32'(b_out), 32'h2b4c1);
    @(posedge pclk) b_en <= 1'b0;
    wt(6);
    chk(32'(b_oe_n), 32'h1);
    // B-to-A: stored word with default offsets, then switch to real time
    @(posedge pclk) a_sel <= 1'b1;
    a_en <= 1'b1;
    i_hb.load(18'h1c3e7);
    chk(32'(fba), 32'(fx(1, 128, 128)));
    chk(32'(a_out), 32'h1c3e7);
    chk(32'(a_oe_n), 32'h0);
    i_hb.put(18'h0a5f0);
    @(posedge pclk) a_sel <= 1'b0;
    // Each cycle of the switch shows old or new, nothing between
    repeat (8) begin
      @(negedge pclk);
      chk(32'(a_out === 18'h1c3e7 || a_out === 18'h0a5f0), 32'h1);
    end
    chk(32'(a_out), 32'h0a5f0);
    @(posedge pclk) a_en <= 1'b0;
    wt(6);
    chk(32'(a_oe_n), 32'h1);
    @(posedge pclk) rst_ba <= 1'b0;
    wt(6);
    chk(32'(fba), 32'h5);
    @(posedge pclk) rst_ba <= 1'b1;
    apb(1'b0, DBF_COUNT_ADDR, 32'h0);
    chk({22'h0, ard[25:16]}, 32'h0);
    // B-to-A offsets after its reset: one edge sets X=Y=16
    i_hb.set_prog(1'b0);
    i_hb.load(18'h00010);
    i_hb.set_prog(1'b1);
    apb(1'b0, DBF_OFS_ADDR, 32'h0);
    chk(ard, 32'h10100305);
    // Two stored words, head advanced from the A side
    @(posedge pclk) a_sel <= 1'b1;
    i_hb.load(18'h3a001);
    i_hb.load(18'h05b72);
    chk(32'(fba), 32'(fx(2, 16, 16)));
    chk(32'(a_out), 32'h3a001);
    i_ha.unload();
    chk(32'(a_out), 32'h05b72);
    chk(32'(fba), 32'(fx(1, 16, 16)));
    // Software flush empties B-to-A; a later unload is ignored
    apb(1'b1, DBF_CTRL_ADDR, 32'h2);
    wt(1);
    chk(32'(fba), 32'h5);
    i_ha.unload();
    chk(32'(fba), 32'h5);
    apb(1'b0, DBF_COUNT_ADDR, 32'h0);
    chk({22'h0, ard[25:16]}, 32'h0);
    final_report();
  end
endmodule : testbench
